// [pkg/sysif_pkg.sv]
// Shared constants and types for the system interface attribute block
package sysif_pkg;
   localparam int NUM_REQ = 8;
   localparam int TLB_DEPTH = 16;
   localparam int PA_W = 40;
   localparam int VA_W = 64;
   localparam int BUS_W = 64;
   localparam int APB_AW = 8;
   localparam int ATTR_W = 2;
   localparam int ATTR_LSB = 58;
   localparam int VA_ATTR_LSB = 57;
   localparam int ENTRY_ATTR_LSB = 30;
   localparam int STATE_W = 2;
   localparam int STATE_LSB = 60;
   localparam int CTRL_W = 3;
   localparam int CTRL_CRT = 0;
   localparam int CTRL_ELIM = 1;
   localparam int CTRL_MODE64 = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
   localparam int STATUS_OTHER_LSB = 8;
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
   localparam logic [APB_AW-1:0] OFS_EVEN = 8'h08;
   localparam logic [APB_AW-1:0] OFS_ODD = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_TLB_WR = 8'h10;
   typedef enum logic [3:0] {
      KIND_BLK_RD = 4'h0,
      KIND_UPGRADE = 4'h1,
      KIND_BLK_WR = 4'h2,
      KIND_DW_RD = 4'h3,
      KIND_SW_RD = 4'h4,
      KIND_PW_RD = 4'h5,
      KIND_DW_WR = 4'h6,
      KIND_SW_WR = 4'h7,
      KIND_PW_WR = 4'h8,
      KIND_ELIM = 4'h9
   } req_kind_t;
   typedef enum logic [1:0] {
      SC_INVALID = 2'h0,
      SC_SHARED = 2'h1,
      SC_CLEAN_EXCL = 2'h2,
      SC_DIRTY_EXCL = 2'h3
   } sc_state_t;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_ADDR = 1'b1
   } emit_state_t;
endpackage

// [pkg/sysif_link_if.sv]
// Carrier between the top module, the attribute table and the number tracker
`timescale 1ns/1ps
interface sysif_link_if #(
   parameter int NREQ = sysif_pkg::NUM_REQ,
   parameter int DEPTH = sysif_pkg::TLB_DEPTH
);
   localparam int IW = $clog2(DEPTH);
   localparam int NW = $clog2(NREQ);
   logic mapped;
   logic [sysif_pkg::ATTR_W-1:0] vaAttr;
   logic [IW-1:0] tlbIdx;
   logic oddPage;
   logic [sysif_pkg::ATTR_W-1:0] attr;
   logic tlbWr;
   logic [IW-1:0] wrIdx;
   logic [sysif_pkg::ATTR_W-1:0] wrEven;
   logic [sysif_pkg::ATTR_W-1:0] wrOdd;
   logic setOwn;
   logic [NW-1:0] ownNum;
   logic setSnoop;
   logic [NW-1:0] snoopNum;
   logic setExt;
   logic [NW-1:0] extNum;
   logic clr;
   logic [NW-1:0] clrNum;
   logic [NREQ-1:0] busy;
   logic [NREQ-1:0] other;
   modport top(output mapped, vaAttr, tlbIdx, oddPage, tlbWr, wrIdx, wrEven, wrOdd,
      setOwn, ownNum, setSnoop, snoopNum, setExt, extNum, clr, clrNum,
      input attr, busy, other);
   modport attrs(input mapped, vaAttr, tlbIdx, oddPage, tlbWr, wrIdx, wrEven, wrOdd,
      output attr);
   modport tracker(input setOwn, ownNum, setSnoop, snoopNum, setExt, extNum, clr, clrNum,
      output busy, other);
endinterface

// [design/uc_attr_table.sv]
// Per-entry uncached attribute store and attribute source select
`timescale 1ns/1ps
module uc_attr_table #(
   parameter int DEPTH = sysif_pkg::TLB_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   sysif_link_if.attrs lnk
);
   import sysif_pkg::*;
   localparam int IW = $clog2(DEPTH);
   logic [ATTR_W-1:0] even_ff [DEPTH];
   logic [ATTR_W-1:0] odd_ff [DEPTH];
   genvar g;
   for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            even_ff[g] <= '0;
            odd_ff[g] <= '0;
         end else if (lnk.tlbWr && lnk.wrIdx == IW'(g)) begin
            even_ff[g] <= lnk.wrEven;
            odd_ff[g] <= lnk.wrOdd;
         end
      end
   end
   // Unmapped takes the address bits, mapped the matching entry [RL12] [RL13]
   assign lnk.attr = !lnk.mapped ? lnk.vaAttr
      : (lnk.oddPage ? odd_ff[lnk.tlbIdx] : even_ff[lnk.tlbIdx]);
endmodule

// [design/req_num_tracker.sv]
// Busy flags per request number, with a mark for numbers held by another device
`timescale 1ns/1ps
module req_num_tracker #(
   parameter int NREQ = sysif_pkg::NUM_REQ
) (
   input wire logic ref_clk,
   input wire logic rst,
   sysif_link_if.tracker lnk
);
   localparam int NW = $clog2(NREQ);
   logic [NREQ-1:0] busy_ff;
   logic [NREQ-1:0] other_ff;
   genvar g;
   for (g = 0; g < NREQ; g++) begin : g_num
      logic hitOwn;
      logic hitSnoop;
      logic hitExt;
      assign hitOwn = lnk.setOwn && lnk.ownNum == NW'(g);
      assign hitSnoop = lnk.setSnoop && lnk.snoopNum == NW'(g);
      assign hitExt = lnk.setExt && lnk.extNum == NW'(g);
      // A set in the clearing cycle wins so no reservation is lost
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            busy_ff[g] <= 1'b0;
            other_ff[g] <= 1'b0;
         end else if (hitOwn || hitSnoop || hitExt) begin
            busy_ff[g] <= 1'b1;
            other_ff[g] <= hitSnoop; // [RL6]
         end else if (lnk.clr && lnk.clrNum == NW'(g)) begin
            busy_ff[g] <= 1'b0;
            other_ff[g] <= 1'b0;
         end
      end
   end
   assign lnk.busy = busy_ff;
   assign lnk.other = other_ff;
endmodule

// [design/sysif_coherency_attr_support.sv]
// Address cycle extras for duplicate tags, directories and uncached attributes
//
// How it works
// RL1 - I/O is plain memory access; no command marks an access as I/O.
// RL2 - Block read address cycle carries the block's former secondary cache state.
// RL3 - Outside duplicate tags must allow blocks in cache or outgoing buffer.
// RL4 - Coordinator normally tags external coherency requests with a free number.
// RL5 - With target mode off, a number busy from another device may be reused.
// RL6 - In slave state, another device's block read or upgrade marks its number busy.
// RL7 - A reusing request takes no free number; its data answers the original.
// RL8 - Eliminate enabled: each Shared or Exclusive block leaving cache issues eliminate; one offered with a core request gets evictReady, no eliminate.
// RL9 - Eliminate address cycle carries physical address and former block state.
// RL10 - Word reads and writes carry the 2-bit attribute on bus bits 59:58.
// RL11 - Block writes from fully gathered uncached blocks carry the attribute too.
// RL12 - Unmapped accesses take the attribute from virtual address bits 58:57.
// RL13 - Mapped accesses use the entry field, loaded from entry-low bits 63:62.
`timescale 1ns/1ps
module sysif_coherency_attr_support #(
   parameter int NREQ = sysif_pkg::NUM_REQ,
   parameter int DEPTH = sysif_pkg::TLB_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [sysif_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reqValid,
   input wire sysif_pkg::req_kind_t reqKind,
   input wire logic [$clog2(NREQ)-1:0] reqNum,
   input wire logic [sysif_pkg::PA_W-1:0] reqPaddr,
   input wire logic [sysif_pkg::VA_W-1:0] reqVaddr,
   input wire logic reqMapped,
   input wire logic [$clog2(DEPTH)-1:0] reqTlbIdx,
   input wire logic reqOddPage,
   input wire sysif_pkg::sc_state_t reqFormerState,
   input wire logic reqGathered,
   output logic reqReady,
   input wire logic evictValid,
   input wire logic [sysif_pkg::PA_W-1:0] evictPaddr,
   input wire sysif_pkg::sc_state_t evictState,
   output logic evictReady,
   input wire logic slaveState,
   input wire logic snoopValid,
   input wire sysif_pkg::req_kind_t snoopKind,
   input wire logic [$clog2(NREQ)-1:0] snoopNum,
   input wire logic doneValid,
   input wire logic [$clog2(NREQ)-1:0] doneNum,
   input wire logic extValid,
   input wire logic [$clog2(NREQ)-1:0] extNum,
   output logic extAccept,
   output logic extReuse,
   output logic extReject,
   output logic addrValid,
   output sysif_pkg::req_kind_t sysCmd,
   output logic [sysif_pkg::BUS_W-1:0] system_addr_data_bus
);
   import sysif_pkg::*;

   localparam int IW = $clog2(DEPTH);

   sysif_link_if #(.NREQ(NREQ), .DEPTH(DEPTH)) lnk ();

   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [ATTR_W-1:0] evenHi_ff;
   logic [ATTR_W-1:0] oddHi_ff;
   emit_state_t state_ff;
   emit_state_t nxt_state;
   logic rdy_ff;
   logic addrValid_ff;
   req_kind_t cmd_ff;
   logic [BUS_W-1:0] bus_ff;
   logic extAccept_ff;
   logic extReuse_ff;
   logic extReject_ff;
   logic apbAcc;
   logic apbTake;
   logic apbWr;
   logic takeReq;
   logic takeEv;
   logic elimGo;
   logic showState;
   logic showAttr;
   logic extBusy;
   logic reuseOk;

   function automatic logic regHit(input logic [APB_AW-1:0] a);
      regHit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_EVEN)
         || (a == OFS_ODD) || (a == OFS_TLB_WR);
   endfunction

   function automatic logic [31:0] regRead(input logic [APB_AW-1:0] a);
      logic [31:0] r;
      r = '0;
      unique case (a)
         OFS_CTRL: begin
            r[CTRL_W-1:0] = ctrl_ff;
         end
         OFS_STATUS: begin
            r[NREQ-1:0] = lnk.busy;
            r[STATUS_OTHER_LSB+:NREQ] = lnk.other;
         end
         OFS_EVEN: begin
            r[ENTRY_ATTR_LSB+:ATTR_W] = evenHi_ff;
         end
         OFS_ODD: begin
            r[ENTRY_ATTR_LSB+:ATTR_W] = oddHi_ff;
         end
         default: begin
            r = '0;
         end
      endcase
      regRead = r;
   endfunction

   // Address cycle layout: address low, former state and attribute high
   function automatic logic [BUS_W-1:0] busWord(
      input logic [PA_W-1:0] pa,
      input logic [STATE_W-1:0] st,
      input logic [ATTR_W-1:0] at
   );
      logic [BUS_W-1:0] w;
      w = '0;
      w[PA_W-1:0] = pa;
      w[STATE_LSB+:STATE_W] = st;
      w[ATTR_LSB+:ATTR_W] = at; // [RL10]
      busWord = w;
   endfunction

   function automatic logic isWordAccess(input req_kind_t k);
      isWordAccess = (k == KIND_DW_RD) || (k == KIND_SW_RD) || (k == KIND_PW_RD)
         || (k == KIND_DW_WR) || (k == KIND_SW_WR) || (k == KIND_PW_WR);
   endfunction

   // APB: one wait state; read data is registered on the same edge that raises pready
   assign apbAcc = psel && penable;
   assign apbTake = apbAcc && pready_ff;
   assign apbWr = apbTake && pwrite;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= apbAcc && !pready_ff;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else if (apbAcc && !pready_ff) begin
         prdata_ff <= pwrite ? '0 : regRead(paddr);
         pslverr_ff <= !regHit(paddr);
      end else if (!apbAcc) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= CTRL_RESET;
      end else if (apbWr && paddr == OFS_CTRL) begin
         ctrl_ff <= pwdata[CTRL_W-1:0];
      end
   end

   // Only bits 63:62 of each entry-low word matter here, held as the upper word
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         evenHi_ff <= '0;
         oddHi_ff <= '0;
      end else if (apbWr && paddr == OFS_EVEN) begin
         evenHi_ff <= pwdata[ENTRY_ATTR_LSB+:ATTR_W];
      end else if (apbWr && paddr == OFS_ODD) begin
         oddHi_ff <= pwdata[ENTRY_ATTR_LSB+:ATTR_W];
      end
   end

   // Entry commit; outside 64-bit mode the field cannot be loaded and reads zero
   assign lnk.tlbWr = apbWr && paddr == OFS_TLB_WR;
   assign lnk.wrIdx = pwdata[IW-1:0];
   assign lnk.wrEven = ctrl_ff[CTRL_MODE64] ? evenHi_ff : '0; // [RL13]
   assign lnk.wrOdd = ctrl_ff[CTRL_MODE64] ? oddHi_ff : '0; // [RL13]

   assign lnk.mapped = reqMapped;
   assign lnk.vaAttr = reqVaddr[VA_ATTR_LSB+:ATTR_W]; // [RL12]
   assign lnk.tlbIdx = reqTlbIdx;
   assign lnk.oddPage = reqOddPage;

   uc_attr_table #(.DEPTH(DEPTH)) u_attr (
      .ref_clk(ref_clk),
      .rst(rst),
      .lnk(lnk.attrs)
   );

   // Request emission; a core request beats a same-cycle eviction, which still sees evictReady and is dropped
   always_comb begin
      takeReq = reqValid && rdy_ff;
      takeEv = evictValid && rdy_ff && !takeReq;
      elimGo = takeEv && ctrl_ff[CTRL_ELIM] && evictState != SC_INVALID; // [RL8]
      showState = reqKind == KIND_BLK_RD; // [RL2]
      showAttr = isWordAccess(reqKind)
         || (reqKind == KIND_BLK_WR && reqGathered); // [RL10] [RL11]
      nxt_state = ST_IDLE;
      unique case (state_ff)
         ST_IDLE: begin
            nxt_state = (takeReq || elimGo) ? ST_ADDR : ST_IDLE;
         end
         ST_ADDR: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         rdy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rdy_ff <= nxt_state == ST_IDLE;
      end
   end

   // The command is only the access kind; I/O travels as ordinary memory access
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         addrValid_ff <= 1'b0;
         cmd_ff <= KIND_BLK_RD;
         bus_ff <= '0;
      end else if (takeReq) begin
         addrValid_ff <= 1'b1;
         cmd_ff <= reqKind; // [RL1]
         bus_ff <= busWord(reqPaddr,
            showState ? reqFormerState : SC_INVALID,
            showAttr ? lnk.attr : '0);
      end else if (elimGo) begin
         addrValid_ff <= 1'b1;
         cmd_ff <= KIND_ELIM;
         bus_ff <= busWord(evictPaddr, evictState, '0); // [RL9]
      end else begin
         addrValid_ff <= 1'b0;
         bus_ff <= '0;
      end
   end

   // Number tracking: own requests, observed requests, external requests
   assign lnk.setOwn = takeReq;
   assign lnk.ownNum = reqNum;
   assign lnk.setSnoop = slaveState && snoopValid
      && (snoopKind == KIND_BLK_RD || snoopKind == KIND_UPGRADE); // [RL6]
   assign lnk.snoopNum = snoopNum;
   assign lnk.clr = doneValid;
   assign lnk.clrNum = doneNum;
   assign lnk.extNum = extNum;

   // Busy status is sampled before this cycle's sets land
   assign extBusy = lnk.busy[extNum];
   assign reuseOk = !ctrl_ff[CTRL_CRT] && lnk.other[extNum]; // [RL5]
   assign lnk.setExt = extValid && !extBusy; // [RL4]

   req_num_tracker #(.NREQ(NREQ)) u_track (
      .ref_clk(ref_clk),
      .rst(rst),
      .lnk(lnk.tracker)
   );

   // A reuse consumes no number; its data goes back as the original's answer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         extAccept_ff <= 1'b0;
         extReuse_ff <= 1'b0;
         extReject_ff <= 1'b0;
      end else begin
         extAccept_ff <= extValid && (!extBusy || reuseOk);
         extReuse_ff <= extValid && extBusy && reuseOk; // [RL7]
         extReject_ff <= extValid && extBusy && !reuseOk; // [RL5]
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign reqReady = rdy_ff;
   assign evictReady = rdy_ff;
   assign extAccept = extAccept_ff;
   assign extReuse = extReuse_ff;
   assign extReject = extReject_ff;
   assign addrValid = addrValid_ff;
   assign sysCmd = cmd_ff;
   assign system_addr_data_bus = bus_ff;
endmodule

// [sim/sysif_coherency_attr_support_checker.sv]
// Checker on the top module ports of the address cycle extras block
`timescale 1ns/1ps
module sysif_coherency_attr_support_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire sysif_pkg::req_kind_t reqKind,
   input wire logic [sysif_pkg::VA_W-1:0] reqVaddr,
   input wire logic reqMapped,
   input wire sysif_pkg::sc_state_t reqFormerState,
   input wire logic reqGathered,
   input wire logic reqReady,
   input wire logic evictValid,
   input wire logic [sysif_pkg::PA_W-1:0] evictPaddr,
   input wire sysif_pkg::sc_state_t evictState,
   input wire logic evictReady,
   input wire logic extValid,
   input wire logic extAccept,
   input wire logic extReuse,
   input wire logic extReject,
   input wire logic addrValid,
   input wire sysif_pkg::req_kind_t sysCmd,
   input wire logic [sysif_pkg::BUS_W-1:0] system_addr_data_bus
);
   import sysif_pkg::*;
   logic take, evTake, word;
   logic [1:0] vaAt;
   assign take = reqValid && reqReady;
   // A core take wins the slot, so an eviction only counts when no request is taken
   assign evTake = evictValid && evictReady && !take;
   assign word = reqKind inside {[KIND_DW_RD:KIND_PW_WR]};
   assign vaAt = reqVaddr[58:57];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_cmd; take |=> addrValid && sysCmd == $past(reqKind); endproperty
   a_cmd: assert property (p_cmd) else $error("command differs from request kind");
   property p_state; take && reqKind == KIND_BLK_RD |=> system_addr_data_bus[61:60] == $past(reqFormerState); endproperty
   a_state: assert property (p_state) else $error("block read former state wrong");
   property p_noAttr; take && !word && !(reqKind == KIND_BLK_WR && reqGathered) |=> system_addr_data_bus[59:58] == 0;
   endproperty
   a_noAttr: assert property (p_noAttr) else $error("attribute on a request without one");
   property p_gather; take && reqKind == KIND_BLK_WR && reqGathered && !reqMapped |=> system_addr_data_bus[59:58] == $past(vaAt);
   endproperty
   a_gather: assert property (p_gather) else $error("gathered block write attribute wrong");
   property p_unmap; take && word && !reqMapped |=> system_addr_data_bus[59:58] == $past(vaAt); endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped attribute wrong");
   property p_elimSt; evTake |=> !addrValid || (sysCmd == KIND_ELIM && system_addr_data_bus[61:60] != SC_INVALID);
   endproperty
   a_elimSt: assert property (p_elimSt) else $error("eliminate for an invalid block");
   property p_elimAd; evTake |=> !addrValid || (system_addr_data_bus[39:0] == $past(evictPaddr)
      && system_addr_data_bus[61:60] == $past(evictState)); endproperty
   a_elimAd: assert property (p_elimAd) else $error("eliminate address cycle wrong");
   property p_pick; extValid |=> extAccept != extReject; endproperty
   a_pick: assert property (p_pick) else $error("external request answer not unique");
   property p_reuse; extReuse |-> extAccept && !extReject; endproperty
   a_reuse: assert property (p_reuse) else $error("reuse without accept");
endmodule
bind sysif_coherency_attr_support sysif_coherency_attr_support_checker i_chk (.ref_clk(ref_clk), .rst(rst),
   .reqValid(reqValid), .reqKind(reqKind), .reqVaddr(reqVaddr), .reqMapped(reqMapped),
   .reqFormerState(reqFormerState), .reqGathered(reqGathered), .reqReady(reqReady), .evictValid(evictValid),
   .evictPaddr(evictPaddr), .evictState(evictState), .evictReady(evictReady), .extValid(extValid),
   .extAccept(extAccept), .extReuse(extReuse), .extReject(extReject), .addrValid(addrValid), .sysCmd(sysCmd),
   .system_addr_data_bus(system_addr_data_bus));

// [sim/coherency_agent_model.sv]
// Cluster coordinator model: other-device traffic and external coherency requests
`timescale 1ns/1ps
module coherency_agent_model (
   input wire logic ref_clk,
   input wire logic extAccept,
   input wire logic extReuse,
   input wire logic extReject,
   output logic slaveState,
   output logic snoopValid,
   output sysif_pkg::req_kind_t snoopKind,
   output logic [2:0] snoopNum,
   output logic doneValid,
   output logic [2:0] doneNum,
   output logic extValid,
   output logic [2:0] extNum
);
   import sysif_pkg::*;
   initial begin
      slaveState = 1'b0;
      snoopValid = 1'b0;
      snoopKind = KIND_SW_RD;
      snoopNum = 3'h0;
      doneValid = 1'b0;
      doneNum = 3'h0;
      extValid = 1'b0;
      extNum = 3'h0;
   end
   // Number is the scenario's pick: free, already busy, or busy from another device's request
   task automatic ext(input logic [2:0] n, input int lag, output logic [2:0] r);
      repeat (lag) @(posedge ref_clk);
      extValid <= 1'b1;
      extNum <= n;
      @(posedge ref_clk);
      extValid <= 1'b0;
      extNum <= ~n;
      @(posedge ref_clk);
      r = {extAccept, extReuse, extReject};
   endtask
   task automatic snoop(input logic sl, input req_kind_t k, input logic [2:0] n);
      @(posedge ref_clk);
      slaveState <= sl;
      snoopValid <= 1'b1;
      snoopKind <= k;
      snoopNum <= n;
      @(posedge ref_clk);
      snoopValid <= 1'b0;
      snoopNum <= ~n;
   endtask
   task automatic done(input logic [2:0] n);
      @(posedge ref_clk);
      doneValid <= 1'b1;
      doneNum <= n;
      @(posedge ref_clk);
      doneValid <= 1'b0;
      doneNum <= ~n;
   endtask
endmodule

// [sim/sysif_coherency_attr_support_tb.sv]
// Self-checking bench for the address cycle extras block
`timescale 1ns/1ps
module sysif_coherency_attr_support_tb;
   import sysif_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, reqReady, evictReady, extAccept, extReuse, extReject, addrValid;
   logic reqValid = 1'b0, reqMapped = 1'b0, reqOddPage = 1'b0, reqGathered = 1'b0, evictValid = 1'b0;
   req_kind_t reqKind = KIND_BLK_RD, sysCmd, snoopKind;
   logic [2:0] reqNum = 3'h0, snoopNum, doneNum, extNum, r;
   logic [39:0] reqPaddr = 40'h0, evictPaddr = 40'h0;
   logic [63:0] reqVaddr = 64'h0, system_addr_data_bus;
   logic [3:0] reqTlbIdx = 4'h3;
   sc_state_t reqFormerState = SC_INVALID, evictState = SC_INVALID;
   logic slaveState, snoopValid, doneValid, extValid;
   int error_cnt = 0, checked = 0;
   sysif_coherency_attr_support i_dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reqValid(reqValid), .reqKind(reqKind), .reqNum(reqNum), .reqPaddr(reqPaddr), .reqVaddr(reqVaddr),
      .reqMapped(reqMapped), .reqTlbIdx(reqTlbIdx), .reqOddPage(reqOddPage), .reqFormerState(reqFormerState),
      .reqGathered(reqGathered), .reqReady(reqReady), .evictValid(evictValid), .evictPaddr(evictPaddr),
      .evictState(evictState), .evictReady(evictReady), .slaveState(slaveState), .snoopValid(snoopValid),
      .snoopKind(snoopKind), .snoopNum(snoopNum), .doneValid(doneValid), .doneNum(doneNum), .extValid(extValid),
      .extNum(extNum), .extAccept(extAccept), .extReuse(extReuse), .extReject(extReject), .addrValid(addrValid),
      .sysCmd(sysCmd), .system_addr_data_bus(system_addr_data_bus));
   coherency_agent_model i_agent (.ref_clk(ref_clk), .extAccept(extAccept), .extReuse(extReuse),
      .extReject(extReject), .slaveState(slaveState), .snoopValid(snoopValid), .snoopKind(snoopKind),
      .snoopNum(snoopNum), .doneValid(doneValid), .doneNum(doneNum), .extValid(extValid), .extNum(extNum));
   initial forever #10 ref_clk = ~ref_clk;
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never gets its answer
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic core(input req_kind_t k, input logic [2:0] num, input logic mp, input logic [1:0] at,
         input sc_state_t st, input logic g);
      logic [1:0] ea, es;
      ea = (k inside {[KIND_DW_RD:KIND_PW_WR]} || (k == KIND_BLK_WR && g)) ? at : 2'h0;
      es = (k == KIND_BLK_RD) ? st : 2'h0;
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqKind <= k;
      reqNum <= num;
      reqMapped <= mp;
      reqOddPage <= at[0];
      reqGathered <= g;
      reqFormerState <= st;
      reqPaddr <= {37'h12345, num};
      // Mapped case puts the wrong value in the address bits, so a wrong source shows
      reqVaddr <= {5'h0, mp ? ~at : at, 57'h0ABC};
      do @(posedge ref_clk); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      @(posedge ref_clk);
      chk("addrValid", 64'h1, addrValid);
      chk("sysCmd", k, sysCmd);
      chk("bus", {2'h0, es, ea, 18'h0, 37'h12345, num}, system_addr_data_bus);
   endtask
   task automatic evict(input sc_state_t st, input logic on);
      logic v;
      v = on && st != SC_INVALID;
      @(posedge ref_clk);
      evictValid <= 1'b1;
      evictState <= st;
      evictPaddr <= 40'h00ABCDE123;
      do @(posedge ref_clk); while (evictReady !== 1'b1);
      evictValid <= 1'b0;
      @(posedge ref_clk);
      chk("elim valid", v, addrValid);
      chk("elim bus", v ? {2'h0, st, 20'h0, 40'h00ABCDE123} : 64'h0, system_addr_data_bus);
   endtask
   task automatic clear_all;
      for (int i = 0; i < 8; i++) i_agent.done(i[2:0]);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status clear", 64'h0, rd);
   endtask
   task automatic t_regs;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl reset", 64'h0, rd);
      apb(1'b1, OFS_CTRL, 32'h7);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", 64'h7, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", 64'h1, err);
   endtask
   task automatic t_kinds;
      apb(1'b1, OFS_CTRL, 32'h0);
      for (int k = 0; k < 9; k++) core(req_kind_t'(k), k[2:0], 1'b0, k[1:0], sc_state_t'(k[1:0]), k[0]);
      core(KIND_BLK_WR, 3'h1, 1'b0, 2'h3, SC_SHARED, 1'b1);
      clear_all();
   endtask
   task automatic t_mapped;
      apb(1'b1, OFS_CTRL, 32'h4);
      apb(1'b1, OFS_EVEN, 32'h80000000);
      apb(1'b1, OFS_ODD, 32'h40000000);
      apb(1'b1, OFS_TLB_WR, 32'h3);
      core(KIND_DW_RD, 3'h1, 1'b1, 2'h2, SC_INVALID, 1'b0);
      core(KIND_SW_WR, 3'h2, 1'b1, 2'h1, SC_INVALID, 1'b0);
      // Outside 64-bit mode the entry loads as zero
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_TLB_WR, 32'h3);
      core(KIND_PW_RD, 3'h3, 1'b1, 2'h0, SC_INVALID, 1'b0);
      clear_all();
   endtask
   task automatic t_elim;
      apb(1'b1, OFS_CTRL, 32'h2);
      for (int s = 0; s < 4; s++) evict(sc_state_t'(s), 1'b1);
      apb(1'b1, OFS_CTRL, 32'h0);
      // No eliminate here, so the far side cannot assume the block has left for good
      evict(SC_DIRTY_EXCL, 1'b0);
   endtask
   task automatic t_ext;
      i_agent.ext(3'h5, 0, r);
      chk("ext free", 64'h4, r);
      i_agent.ext(3'h5, 0, r);
      chk("ext busy own", 64'h1, r);
      core(KIND_BLK_RD, 3'h2, 1'b0, 2'h0, SC_SHARED, 1'b0);
      i_agent.ext(3'h2, 0, r);
      chk("ext own req", 64'h1, r);
      i_agent.snoop(1'b1, KIND_UPGRADE, 3'h6);
      i_agent.snoop(1'b0, KIND_BLK_RD, 3'h7);
      i_agent.snoop(1'b1, KIND_BLK_WR, 3'h4);
      i_agent.snoop(1'b1, KIND_BLK_RD, 3'h3);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status", 64'h486C, rd);
      i_agent.ext(3'h6, 3, r);
      chk("ext reuse", 64'h6, r);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status reuse", 64'h486C, rd);
      apb(1'b1, OFS_CTRL, 32'h1);
      i_agent.ext(3'h6, 0, r);
      chk("ext target mode", 64'h1, r);
      clear_all();
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_kinds();
      t_mapped();
      t_elim();
      t_ext();
      report_and_stop();
   end
endmodule
